/* File: hw/sosc_pkg.sv */
// Constants, field layout and state codes for the output and sleep control block
package sosc_pkg;
  localparam int DQ_W       = 36;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int ADDR_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W     = ADDR_W + LANES + DQ_W;
  localparam int LVL_W      = 6;
  localparam int CNT_W      = 3;
  localparam int RDCNT_W    = 16;

  // Timing, in the unit printed, and derived cycle counts
  localparam int CLK_PERIOD_PS   = 40000;
  localparam int SLEEP_ENTRY_NS  = 7;
  localparam int WAKE_MIN_NS     = 7;
  localparam int WAKE_RETAIN_NS  = 200;
  localparam int ENTRY_RAW       = (SLEEP_ENTRY_NS * 1000) / CLK_PERIOD_PS;
  localparam int ENTRY_CYC       = (ENTRY_RAW < 1) ? 1 : ENTRY_RAW;
  localparam int WAKE_MIN_CYC    = (WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_RETAIN_CYC = (WAKE_RETAIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] RETAIN_LAST = CNT_W'(WAKE_RETAIN_CYC - 1);

  // Register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_EVENTS = 12'h008;
  localparam logic [11:0] REG_RDCNT  = 12'h00C;

  // Field positions
  localparam int CTRL_DRAIN  = 0;
  localparam int CTRL_BLOCK  = 1;
  localparam int ST_SLEEPING = 0;
  localparam int ST_RECOVERY = 1;
  localparam int ST_FULL     = 2;
  localparam int ST_LVL_LSB  = 3;
  localparam int EV_EARLY    = 0;
  localparam int EV_DROP     = 1;
  localparam int EV_RETAIN   = 2;
  localparam int EV_W        = 3;

  localparam logic [1:0] CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {
    ST_AWAKE   = 3'h1,
    ST_SLEEP   = 3'h2,
    ST_RECOVER = 3'h4
  } sosc_state_t;
endpackage : sosc_pkg

/* File: hw/sosc_fifo_if.sv */
// Handshake bundle between the write queue and its producer and consumer
`timescale 1ns/1ps
interface sosc_fifo_if #(parameter int WIDTH = 8, parameter int LVL_W = 6);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic [LVL_W-1:0] level;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, level);
endinterface : sosc_fifo_if

/* File: hw/sosc_fifo.sv */
// Write queue between the pins and the storage array
`timescale 1ns/1ps
module sosc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  input wire logic clk_sys,
  input wire logic reset,
  sosc_fifo_if.fifo q
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [LVL_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  assign q.in_ready  = (cnt_q != LVL_W'(DEPTH));
  assign q.out_valid = (cnt_q != '0);
  assign q.out_data  = mem[rd_q];
  assign q.level     = cnt_q;
  assign push        = q.in_valid & q.in_ready;
  assign pop         = q.out_valid & q.out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= q.in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + PW'(1);
      end
      cnt_q <= cnt_q + LVL_W'(push) - LVL_W'(pop);
    end
  end
endmodule : sosc_fifo

/* File: hw/sosc_top.sv */
// Output drive and sleep control of a pipelined synchronous memory, with APB status
`timescale 1ns/1ps
// Summary of operation
// (RL1) While sleep is requested every other input is ignored and the data pins float at the next edge and the one after.
// (RL2) A read with output enable low drives the whole 36-bit word onto the data pins.
// (RL3) A read with output enable high leaves the data pins floating.
// (RL4) A write cycle leaves the data pins floating whatever the output enable.
// (RL5) A deselect cycle leaves the data pins floating whatever the output enable.
// (RL6) The controller waits at least 7 ns after sleep ends before a new operation.
// (RL7) Sleep with low power and floating pins is reached within 7 ns of the request.
// (RL8) The controller should allow 200 ns of recovery to keep stored data safe.
// (RL9) Read address and controls are taken on one edge and the word appears after the next.
// (RL10) The controller requests sleep only once pending operations have finished.
// (RL11) Sleep keeps the array contents and normal work resumes when the request falls; the block applies queued writes only after the 5-cycle recovery state.
// (RL12) The pin enable joins the registered read flag with output enable, sleep request and the CTRL_BLOCK control bit.
module sosc_top
  import sosc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata_q,
  output logic                   pready_q,
  output logic                   pslverr_q,
  input  wire logic              sleep_request,
  input  wire logic              chip_sel_n,
  input  wire logic              global_write_n,
  input  wire logic [LANES-1:0]  byte_write_n,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DQ_W-1:0]   dq_in,
  input  wire logic              out_enable_n,
  output logic      [DQ_W-1:0]   dq_out_q,
  output logic                   dq_oe_q,
  output logic                   low_power_q
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_EVENTS) || (a == REG_RDCNT);
  endfunction : reg_hit

  function automatic logic [DQ_W-1:0] lane_mask(input logic [LANES-1:0] be_n);
    lane_mask = '0;
    for (int l = 0; l < LANES; l++) begin
      lane_mask[l*LANE_W +: LANE_W] = {LANE_W{~be_n[l]}};
    end
  endfunction : lane_mask

  // ****************************************
  // Declarations
  // ****************************************
  logic [DQ_W-1:0]    array_q [2**ADDR_W];
  sosc_state_t        state_q;
  sosc_state_t        state_d;
  logic [CNT_W-1:0]   rcnt_q;
  logic               rd_q;
  logic [ADDR_W-1:0]  raddr_q;
  logic [1:0]         ctrl_q;
  logic [EV_W-1:0]    ev_q;
  logic [EV_W-1:0]    ev_set;
  logic [RDCNT_W-1:0] rdcnt_q;
  logic               cyc_sel;
  logic               cyc_read;
  logic               cyc_write;
  logic               oe_d;
  logic               setup;
  logic               access;
  logic [31:0]        rd_mux;
  logic [ADDR_W-1:0]  dr_addr;
  logic [LANES-1:0]   dr_be_n;
  logic [DQ_W-1:0]    dr_data;
  logic [DQ_W-1:0]    dr_mask;

  sosc_fifo_if #(.WIDTH(FIFO_W), .LVL_W(LVL_W)) wq();

  sosc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH),
    .LVL_W (LVL_W)
  ) u_wq (
    .clk_sys (clk_sys),
    .reset   (reset),
    .q       (wq)
  );

  // ****************************************
  // Cycle decode at the pins
  // ****************************************
  assign cyc_sel   = ~sleep_request & ~chip_sel_n; // RL1
  assign cyc_read  = cyc_sel & global_write_n; // RL4 RL5
  assign cyc_write = cyc_sel & ~global_write_n & ~&byte_write_n;

  assign wq.in_valid  = cyc_write;
  assign wq.in_data   = {mem_addr, byte_write_n, dq_in};
  // Array updates pause while asleep or recovering
  assign wq.out_ready = ctrl_q[CTRL_DRAIN] & (state_q == ST_AWAKE); // RL11
  assign {dr_addr, dr_be_n, dr_data} = wq.out_data;
  assign dr_mask = lane_mask(dr_be_n);

  // ****************************************
  // Sleep state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_AWAKE: begin
        if (sleep_request) begin
          state_d = ST_SLEEP; // RL7
        end
      end
      ST_SLEEP: begin
        if (!sleep_request) begin
          state_d = ST_RECOVER; // RL11
        end
      end
      ST_RECOVER: begin
        if (sleep_request) begin
          state_d = ST_SLEEP;
        end else if (rcnt_q == RETAIN_LAST) begin
          state_d = ST_AWAKE; // RL8
        end
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q     <= ST_AWAKE;
      low_power_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      low_power_q <= (state_d == ST_SLEEP); // RL7
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rcnt_q <= '0;
    end else if (state_q != ST_RECOVER) begin
      rcnt_q <= '0;
    end else begin
      rcnt_q <= rcnt_q + CNT_W'(1);
    end
  end

  // ****************************************
  // Read pipeline and pin drive
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_q    <= 1'b0;
      raddr_q <= '0;
    end else begin
      rd_q <= cyc_read; // RL9
      if (cyc_read) begin
        raddr_q <= mem_addr;
      end
    end
  end

  // Writes and deselects never set the read flag, so the pins stay off
  assign oe_d = rd_q & ~out_enable_n & ~sleep_request & ~ctrl_q[CTRL_BLOCK]; // RL12

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dq_oe_q  <= 1'b0;
      dq_out_q <= '0;
    end else begin
      dq_oe_q <= oe_d; // RL3
      if (rd_q) begin
        dq_out_q <= array_q[raddr_q]; // RL2
      end
    end
  end

  // ****************************************
  // Storage array, written from the queue
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (wq.out_valid && wq.out_ready) begin
      array_q[dr_addr] <= (array_q[dr_addr] & ~dr_mask) | (dr_data & dr_mask);
    end
  end

  // ****************************************
  // Event flags and counters
  // ****************************************
  always_comb begin
    ev_set           = '0;
    ev_set[EV_EARLY] = (state_q == ST_SLEEP) & ~sleep_request & ~chip_sel_n; // RL6
    ev_set[EV_DROP]  = wq.in_valid & ~wq.in_ready; // RL10
    ev_set[EV_RETAIN] = (state_q == ST_RECOVER) & cyc_sel; // RL8
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ev_q <= '0;
    end else if (access && pwrite && paddr == REG_EVENTS) begin
      ev_q <= (ev_q & ~pwdata[EV_W-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdcnt_q <= '0;
    end else if (access && pwrite && paddr == REG_RDCNT) begin
      rdcnt_q <= '0;
    end else if (cyc_read) begin
      rdcnt_q <= rdcnt_q + RDCNT_W'(1);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_q;

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      REG_CTRL: begin
        rd_mux[1:0] = ctrl_q;
      end
      REG_STATUS: begin
        rd_mux[ST_SLEEPING] = (state_q == ST_SLEEP);
        rd_mux[ST_RECOVERY] = (state_q == ST_RECOVER);
        rd_mux[ST_FULL]     = ~wq.in_ready;
        rd_mux[ST_LVL_LSB +: LVL_W] = wq.level;
      end
      REG_EVENTS: begin
        rd_mux[EV_W-1:0] = ev_q;
      end
      REG_RDCNT: begin
        rd_mux[RDCNT_W-1:0] = rdcnt_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~reg_hit(paddr);
      prdata_q  <= (setup && !pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (access && pwrite && paddr == REG_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_SLEEP_HIZ: assert property (sleep_request |=> !dq_oe_q ##1 !dq_oe_q) // RL1
    else $error("pins driven during or after sleep request");
  AST_READ_DRIVE: assert property (cyc_read ##1 (!out_enable_n && !sleep_request
    && !ctrl_q[CTRL_BLOCK]) |=> dq_oe_q) // RL2
    else $error("enabled read did not drive pins");
  AST_OE_HIZ: assert property (dq_oe_q |-> !$past(out_enable_n)) // RL3
    else $error("pins driven with output enable high");
  AST_WRITE_HIZ: assert property (!sleep_request && !chip_sel_n && !global_write_n
    |=> ##1 !dq_oe_q) // RL4
    else $error("pins driven after write cycle");
  AST_DESEL_HIZ: assert property (chip_sel_n |=> ##1 !dq_oe_q) // RL5
    else $error("pins driven after deselect");
  AST_READ_PIPE: assert property (dq_oe_q |-> $past(cyc_read, 2)) // RL9
    else $error("pin drive without read two edges before");
  AST_ENTRY: assert property (sleep_request |=> low_power_q && !dq_oe_q) // RL7
    else $error("sleep not reached within entry time");
  AST_EARLY: assert property (state_q == ST_SLEEP && !sleep_request && !chip_sel_n
    |=> ev_q[EV_EARLY]) // RL6
    else $error("early wake operation not flagged");
  AST_RECOVER_LEN: assert property ((state_q == ST_SLEEP && !sleep_request)
    ##1 (!sleep_request)[*5] |=> state_q == ST_AWAKE) // RL8
    else $error("recovery length wrong");
  AST_HOLD_ARRAY: assert property (state_q != ST_AWAKE |-> !wq.out_ready) // RL11
    else $error("array written during sleep or recovery");
  AST_DROP: assert property (wq.in_valid && !wq.in_ready |=> ev_q[EV_DROP]) // RL10
    else $error("dropped write not flagged");

  COV_READ: cover property (cyc_read ##1 !out_enable_n ##1 dq_oe_q);
  COV_SLEEP: cover property (state_q == ST_AWAKE ##1 state_q == ST_SLEEP);
  COV_WAKE: cover property (state_q == ST_RECOVER ##1 state_q == ST_AWAKE);
  COV_FULL: cover property (!wq.in_ready);
endmodule : sosc_top

/* File: verif/sosc_ctrl_model.sv */
// Memory controller model driving the pin side of the block
`timescale 1ns/1ps
module sosc_ctrl_model
  import sosc_pkg::*;
(
  input  wire logic              clk_sys,
  output logic                   sleep_request,
  output logic                   chip_sel_n,
  output logic                   global_write_n,
  output logic      [LANES-1:0]  byte_write_n,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DQ_W-1:0]   dq_in,
  output logic                   out_enable_n
);
  initial begin
    sleep_request  = 1'h0;
    chip_sel_n     = 1'h1;
    global_write_n = 1'h1;
    byte_write_n   = 4'hF;
    mem_addr       = 8'h00;
    dq_in          = 36'h0;
    out_enable_n   = 1'h1;
  end
  // One pin cycle, launched just after a rising edge
  task op(input logic cs_n, we_n, input logic [3:0] bw, input logic [7:0] a,
          input logic [35:0] d, input logic oe_n, zz);
    @(posedge clk_sys);
    chip_sel_n     <= cs_n;
    global_write_n <= we_n;
    byte_write_n   <= bw;
    mem_addr       <= a;
    out_enable_n   <= oe_n;
    sleep_request  <= zz;
    // Undriven data lines toggle so stale values never match
    dq_in          <= (!cs_n && !we_n) ? d : ~dq_in;
  endtask : op
  // Quiet gap after sleep before any new operation
  task recover();
    repeat (WAKE_RETAIN_CYC) op(1'h1, 1'h1, 4'hF, 8'h00, 36'h0, 1'h1, 1'h0);
  endtask : recover
endmodule : sosc_ctrl_model

/* File: verif/test_sync_sram_output_sleep_control.sv */
// Self-checking bench for the output drive and sleep control block
`timescale 1ns/1ps
module test_sync_sram_output_sleep_control
  import sosc_pkg::*;
;
  logic              clk_sys;
  logic              reset;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              sleep_request;
  logic              chip_sel_n;
  logic              global_write_n;
  logic [LANES-1:0]  byte_write_n;
  logic [ADDR_W-1:0] mem_addr;
  logic [DQ_W-1:0]   dq_in;
  logic              out_enable_n;
  logic [DQ_W-1:0]   dq_out_q;
  logic              dq_oe_q;
  logic              low_power_q;
  logic [31:0]       rd;
  logic              err;
  int                errors;
  int                samples_checked;

  sosc_top u_sosc_top (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .sleep_request, .chip_sel_n, .global_write_n,
    .byte_write_n, .mem_addr, .dq_in, .out_enable_n, .dq_out_q, .dq_oe_q, .low_power_q);
  sosc_ctrl_model u_sosc_ctrl_model (.clk_sys, .sleep_request, .chip_sel_n,
    .global_write_n, .byte_write_n, .mem_addr, .dq_in, .out_enable_n);

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task miss(input string msg);
    errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : miss
  task check_word(input logic [35:0] got, exp, input string msg);
    samples_checked++;
    if (got !== exp) miss(msg);
  endtask : check_word
  task check_flag(input logic got, exp, input string msg);
    check_word({35'h0, got}, {35'h0, exp}, msg);
  endtask : check_flag
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready_q !== 1'h1 && n < 20);
    if (pready_q !== 1'h1) begin
      miss("bus timeout");
      stop_test();
    end
    rd = prdata_q;
    err = pslverr_q;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task idle(input logic oe_n);
    u_sosc_ctrl_model.op(1'h1, 1'h1, 4'hF, 8'h00, 36'h0, oe_n, 1'h0);
  endtask : idle
  task write_word(input logic [7:0] a, input logic [35:0] d);
    int n;
    u_sosc_ctrl_model.op(1'h0, 1'h0, 4'h0, a, d, 1'h1, 1'h0);
    idle(1'h1);
    n = 0;
    do begin
      apb(1'h0, REG_STATUS, 32'h0);
      n++;
    end while (rd[ST_LVL_LSB +: LVL_W] !== 6'h0 && n < 20);
    if (n >= 20) begin
      miss("queue never drained");
      stop_test();
    end
  endtask : write_word
  task read_chk(input logic [7:0] a, input logic oe_n, eoe, input logic [35:0] exp);
    u_sosc_ctrl_model.op(1'h0, 1'h1, 4'hF, a, 36'h0, oe_n, 1'h0);
    idle(oe_n);
    idle(oe_n);
    #1;
    check_flag(dq_oe_q, eoe, "read drive");
    if (eoe) check_word(dq_out_q, exp, "read data");
  endtask : read_chk

  // ****************************************
  // Scenarios
  // ****************************************
  task s_regs();
    apb(1'h0, REG_CTRL, 32'h0);
    check_word({4'h0, rd}, {34'h0, CTRL_RESET}, "ctrl reset value");
    apb(1'h0, 12'h010, 32'h0);
    check_flag(err, 1'h1, "unmapped not refused");
    apb(1'h0, REG_RDCNT, 32'h0);
    check_word({4'h0, rd}, 36'h0, "read count after reset");
  endtask : s_regs
  task s_full();
    apb(1'h1, REG_CTRL, 32'h0);
    for (int k = 0; k < 33; k++) begin
      u_sosc_ctrl_model.op(1'h0, 1'h0, 4'h0, 8'h5A, 36'h0, 1'h1, 1'h0);
    end
    idle(1'h1);
    apb(1'h0, REG_STATUS, 32'h0);
    check_flag(rd[ST_FULL], 1'h1, "queue not full");
    apb(1'h0, REG_EVENTS, 32'h0);
    check_flag(rd[EV_DROP], 1'h1, "drop not flagged");
    apb(1'h1, REG_EVENTS, 32'h7);
    apb(1'h1, REG_CTRL, 32'h1);
    write_word(8'h5A, 36'h0);
  endtask : s_full
  task s_read();
    write_word(8'h3C, 36'h9A5C35A69);
    read_chk(8'h3C, 1'h0, 1'h1, 36'h9A5C35A69);
    read_chk(8'h3C, 1'h1, 1'h0, 36'h0);
  endtask : s_read
  task s_no_drive();
    for (int k = 0; k < 2; k++) begin
      u_sosc_ctrl_model.op(1'h0, 1'h1, 4'hF, 8'h3C, 36'h0, 1'h0, 1'h0);
      u_sosc_ctrl_model.op(k[0], 1'h0, 4'h0, 8'h3C, 36'h9A5C35A69, 1'h0, 1'h0);
      idle(1'h0);
      #1;
      check_word(dq_out_q, 36'h9A5C35A69, "read before write");
      idle(1'h0);
      #1;
      check_flag(dq_oe_q, 1'h0, "write or deselect drives");
    end
  endtask : s_no_drive
  task s_block();
    apb(1'h1, REG_CTRL, 32'h3);
    read_chk(8'h3C, 1'h0, 1'h0, 36'h0);
    apb(1'h1, REG_CTRL, 32'h1);
    read_chk(8'h3C, 1'h0, 1'h1, 36'h9A5C35A69);
  endtask : s_block
  task s_sleep();
    write_word(8'hC3, 36'h3C3C3C3C3);
    u_sosc_ctrl_model.op(1'h0, 1'h0, 4'h0, 8'hC3, 36'hC3C3C3C3C, 1'h0, 1'h1);
    u_sosc_ctrl_model.op(1'h0, 1'h1, 4'hF, 8'hC3, 36'h0, 1'h0, 1'h1);
    #1;
    check_flag(low_power_q, 1'h1, "sleep entry");
    check_flag(dq_oe_q, 1'h0, "drive in sleep");
    idle(1'h0);
    #1;
    check_flag(dq_oe_q, 1'h0, "drive in sleep");
    idle(1'h0);
    #1;
    check_flag(dq_oe_q, 1'h0, "drive after sleep");
    check_flag(low_power_q, 1'h0, "sleep exit");
    apb(1'h0, REG_STATUS, 32'h0);
    check_flag(rd[ST_RECOVERY], 1'h1, "not recovering");
    u_sosc_ctrl_model.recover();
    read_chk(8'hC3, 1'h0, 1'h1, 36'h3C3C3C3C3);
    apb(1'h0, REG_EVENTS, 32'h0);
    check_word({4'h0, rd}, 36'h0, "spurious event");
  endtask : s_sleep

  initial begin
    errors = 0;
    samples_checked = 0;
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    s_regs();
    s_read();
    s_no_drive();
    s_block();
    s_full();
    s_sleep();
    stop_test();
  end
endmodule : test_sync_sram_output_sleep_control
